/* File: logic/sdt_pkg.sv */
/*
  sdt_pkg: constants and carrier structs for the sdram command and data timing core.
  Assumes one 200 MHz clock; all command pins are sampled on its rising edge.
*/
package sdt_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned LANES            = 4;
  localparam int unsigned BANK_W           = 2;
  localparam int unsigned ROW_W            = 4;
  localparam int unsigned COL_W            = 4;
  localparam int unsigned ADDR_W           = BANK_W + ROW_W + COL_W;
  localparam int unsigned DEPTH            = 1 << ADDR_W;
  // latencies in cycles
  localparam int unsigned CKE_ENTRY_LAT    = 1;
  localparam int unsigned CKE_EXIT_LAT     = 1;
  localparam int unsigned MASK_READ_LAT    = 2;
  localparam int unsigned OFF_LAT_RL3      = 3;
  localparam int unsigned OFF_LAT_RL2      = 2;
  localparam int unsigned PIPE_LEN         = 3;
  localparam logic [1:0]  RL_TWO           = 2'h2;
  localparam logic [1:0]  RL_THREE         = 2'h3;
  localparam logic [3:0]  BURST_LEN        = 4'h4;

  // command encodings on {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDT_NOP     = 4'h7,
    SDT_ACTIVE  = 4'h3,
    SDT_READ    = 4'h5,
    SDT_WRITE   = 4'h4,
    SDT_BSTOP   = 4'h6,
    SDT_PRECHG  = 4'h2,
    SDT_REFRESH = 4'h1,
    SDT_LOADMR  = 4'h0
  } sdt_cmd_e;

  typedef struct packed {
    logic [3:0]        cmd;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  addr;
  } sdt_cmd_s;

  typedef struct packed {
    logic              valid;
    logic              mask_off;
    logic [DATA_W-1:0] data;
  } sdt_rd_s;
endpackage

/* File: logic/sdt_core.sv */
/*
  sdt_core: behavioural core of a 4-bank 32-bit synchronous dram, command decode,
  burst engine, byte masks, clock suspend and output turn-off timing.
  Assumes the controller keeps all spacing it is responsible for; none is checked here.
*/
`timescale 1ns/1ps

module sdt_core (
  input  wire logic                           i_clk,
  input  wire logic                           i_nrst,
  input  wire logic                           i_cke,
  input  wire sdt_pkg::sdt_cmd_s              i_cmd,
  input  wire logic [sdt_pkg::COL_W-1:0]      i_col,
  input  wire logic [sdt_pkg::DATA_W-1:0]     i_dq,
  input  wire logic [sdt_pkg::LANES-1:0]      i_dqm,
  input  wire logic [1:0]                     i_read_latency_setting,
  output logic      [sdt_pkg::DATA_W-1:0]     o_dq,
  output logic      [sdt_pkg::LANES-1:0]      o_dq_oe,
  output logic                                o_suspended
);
  // *************************************************
  // clock gate
  // *************************************************
  logic suspend_r;
  logic active;

  // one-cycle entry and exit: the pin sampled now rules the next cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      suspend_r <= 1'b0;
    end else begin
      suspend_r <= ~i_cke;
    end
  end
  assign active      = ~suspend_r;
  assign o_suspended = suspend_r;

  // *************************************************
  // row state and storage
  // *************************************************
  logic [sdt_pkg::ROW_W-1:0]  open_row_r [sdt_pkg::LANES];
  // lane width of one byte-mask bit
  localparam int unsigned LANE_W = sdt_pkg::DATA_W / sdt_pkg::LANES;

  logic [LANE_W-1:0]          rd_lane [sdt_pkg::LANES];
  logic [sdt_pkg::DATA_W-1:0] rd_word;
  logic [sdt_pkg::LANES-1:0]  masked_rd_r [sdt_pkg::MASK_READ_LAT];

  function automatic logic [sdt_pkg::ADDR_W-1:0] word_index(
    input logic [sdt_pkg::BANK_W-1:0] bank,
    input logic [sdt_pkg::ROW_W-1:0]  row,
    input logic [sdt_pkg::COL_W-1:0]  col
  );
    word_index = {bank, row, col};
  endfunction

  function automatic logic is_cmd(input sdt_pkg::sdt_cmd_s c, input sdt_pkg::sdt_cmd_e k);
    is_cmd = (c.cmd == k);
  endfunction

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int b = 0; b < sdt_pkg::LANES; b++) begin
        open_row_r[b] <= '0;
      end
    end else if (active && is_cmd(i_cmd, sdt_pkg::SDT_ACTIVE)) begin
      open_row_r[i_cmd.bank] <= i_cmd.addr;
    end
  end

  // *************************************************
  // burst engine
  // *************************************************
  localparam logic [3:0] BURST_LEN_M1 = sdt_pkg::BURST_LEN - 4'h1;

  logic                       wr_burst_r;
  logic                       rd_burst_r;
  logic [sdt_pkg::ADDR_W-1:0] wr_idx;
  logic [sdt_pkg::ADDR_W-1:0] rd_idx;
  logic [3:0]                 beat_r;
  logic [sdt_pkg::BANK_W-1:0] bank_r;
  logic [sdt_pkg::COL_W-1:0]  col_r;
  logic                       new_wr;
  logic                       new_rd;
  logic                       stop;
  logic                       wr_now;
  logic [sdt_pkg::BANK_W-1:0] wr_bank;
  logic [sdt_pkg::COL_W-1:0]  wr_col;

  // *************************************************
  // command decode
  // *************************************************
  // refresh and mode load are taken as no-ops: burst length is fixed,
  // and storage is flip-flops, so nothing here ever needs refreshing
  assign new_wr = active && is_cmd(i_cmd, sdt_pkg::SDT_WRITE);
  assign new_rd = active && is_cmd(i_cmd, sdt_pkg::SDT_READ);
  assign stop   = active && (is_cmd(i_cmd, sdt_pkg::SDT_BSTOP) || is_cmd(i_cmd, sdt_pkg::SDT_PRECHG));
  // write data is taken on the command edge itself, no gap
  // the beat count stops the burst after its last word, no fifth write
  assign wr_now  = new_wr || (active && wr_burst_r && !stop && !new_rd && beat_r != '0);
  assign wr_bank = new_wr ? i_cmd.bank : bank_r;
  assign wr_col  = new_wr ? i_col : col_r;
  assign wr_idx  = word_index(wr_bank, open_row_r[wr_bank], wr_col);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_burst_r <= 1'b0;
      rd_burst_r <= 1'b0;
      beat_r     <= '0;
      bank_r     <= '0;
      col_r      <= '0;
    end else if (active) begin
      if (new_wr || new_rd) begin
        wr_burst_r <= new_wr;
        rd_burst_r <= new_rd;
        beat_r     <= BURST_LEN_M1;
        bank_r     <= i_cmd.bank;
        col_r      <= i_col + 1'b1;
      end else if (stop || beat_r == '0) begin
        wr_burst_r <= 1'b0;
        rd_burst_r <= 1'b0;
      end else begin
        beat_r <= beat_r - 1'b1;
        col_r  <= col_r + 1'b1;
      end
    end
  end

  // *************************************************
  // storage
  // *************************************************
  // each lane owns its array, so every array has one writer; a masked lane
  // is simply not written on the edge that carries its data
  for (genvar l = 0; l < sdt_pkg::LANES; l++) begin : g_lane
    logic [LANE_W-1:0] lane_mem_r [sdt_pkg::DEPTH];

    always_ff @(posedge i_clk) begin
      if (wr_now && !i_dqm[l]) begin
        lane_mem_r[wr_idx] <= i_dq[l*LANE_W +: LANE_W];
      end
    end

    assign rd_lane[l] = lane_mem_r[rd_idx];
  end

  // *************************************************
  // read pipeline and output turn-off
  // *************************************************
  sdt_pkg::sdt_rd_s           pipe_r [sdt_pkg::PIPE_LEN];
  logic                       rd_now;
  logic [sdt_pkg::BANK_W-1:0] rd_bank;
  logic [sdt_pkg::COL_W-1:0]  rd_col;
  logic [1:0]                 tap;

  // a cut only stops new beats; beats already in the pipe still drain,
  // so the turn-off follows the read latency
  assign rd_now  = new_rd || (active && rd_burst_r && !stop && !new_wr && beat_r != '0);
  assign rd_idx  = word_index(rd_bank, open_row_r[rd_bank], rd_col);

  always_comb begin
    for (int l = 0; l < sdt_pkg::LANES; l++) begin
      rd_word[l*LANE_W +: LANE_W] = rd_lane[l];
    end
  end
  assign rd_bank = new_rd ? i_cmd.bank : bank_r;
  assign rd_col  = new_rd ? i_col : col_r;
  // latency two taps one stage earlier, so precharge cut lands at two cycles
  assign tap     = (i_read_latency_setting == sdt_pkg::RL_TWO) ? 2'h1 : 2'h2;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int s = 0; s < sdt_pkg::PIPE_LEN; s++) begin
        pipe_r[s] <= '0;
      end
    end else if (active) begin
      pipe_r[0].valid    <= rd_now;
      pipe_r[0].mask_off <= 1'b0;
      pipe_r[0].data     <= rd_word;
      for (int s = 1; s < sdt_pkg::PIPE_LEN; s++) begin
        pipe_r[s] <= pipe_r[s-1];
      end
    end
  end

  // *************************************************
  // read byte mask
  // *************************************************
  // mask sampled now floats lanes two edges later; frozen with the pipe
  // during suspend so mask and data stay aligned
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int s = 0; s < sdt_pkg::MASK_READ_LAT; s++) begin
        masked_rd_r[s] <= '0;
      end
    end else if (active) begin
      masked_rd_r[0] <= i_dqm;
      for (int s = 1; s < sdt_pkg::MASK_READ_LAT; s++) begin
        masked_rd_r[s] <= masked_rd_r[s-1];
      end
    end
  end

  // *************************************************
  // outputs
  // *************************************************
  always_comb begin
    o_dq    = pipe_r[tap].data;
    o_dq_oe = pipe_r[tap].valid ? ~masked_rd_r[sdt_pkg::MASK_READ_LAT-1] : '0;
  end
endmodule

/* File: tb/sdt_core_sva.sv */
/* sdt_core_sva: port assertions for sdt_core.
   Assumes the single clock and the asynchronous low reset. */
`timescale 1ns/1ps
module sdt_core_sva (
  input wire logic                      i_clk,
  input wire logic                      i_nrst,
  input wire logic                      i_cke,
  input wire sdt_pkg::sdt_cmd_s         i_cmd,
  input wire logic [sdt_pkg::LANES-1:0] i_dqm,
  input wire logic [1:0]                i_read_latency_setting,
  input wire logic [sdt_pkg::LANES-1:0] o_dq_oe,
  input wire logic                      o_suspended
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic run, rd, pc, rl2, rl3, nop;
  assign run = i_cke && !o_suspended;
  assign rd  = run && i_cmd.cmd == sdt_pkg::SDT_READ;
  assign pc  = run && i_cmd.cmd == sdt_pkg::SDT_PRECHG;
  assign nop = i_cmd.cmd == sdt_pkg::SDT_NOP;
  assign rl2 = i_read_latency_setting == sdt_pkg::RL_TWO;
  assign rl3 = i_read_latency_setting == sdt_pkg::RL_THREE;
  a_enter_suspend: assert property (!i_cke |=> o_suspended) else $error("suspend late");
  a_leave_suspend: assert property (i_cke |=> !o_suspended) else $error("resume late");
  a_frozen_pipe: assert property (o_suspended |=> $stable(o_dq_oe)) else $error("pipe moved");
  a_read_rl2: assert property (rd && rl2 && i_dqm == 4'h0 |-> ##2 o_dq_oe == 4'hf)
    else $error("rl2 beat missing");
  a_read_rl3: assert property (rd && rl3 ##1 i_cke && i_dqm == 4'h0 |-> ##2 o_dq_oe == 4'hf)
    else $error("rl3 beat missing");
  a_mask_float: assert property (run && i_dqm[1] |-> ##2 !o_dq_oe[1])
    else $error("masked lane driven");
  a_pre_off2: assert property (pc && rl2 |-> ##2 o_dq_oe == 4'h0)
    else $error("rl2 turn-off late");
  a_pre_off3: assert property (pc && rl3 ##1 i_cke |-> ##2 o_dq_oe == 4'h0)
    else $error("rl3 turn-off late");
  c_read2: cover property (rd && rl2);
  c_cut3: cover property (pc && rl3);
  c_resume: cover property (o_suspended ##1 !o_suspended);
endmodule
bind sdt_core sdt_core_sva u_sva (.i_clk(i_clk), .i_nrst(i_nrst), .i_cke(i_cke), .i_cmd(i_cmd), .i_dqm(i_dqm),
  .i_read_latency_setting(i_read_latency_setting), .o_dq_oe(o_dq_oe), .o_suspended(o_suspended));

/* File: tb/sdt_ctl_model.sv */
/* sdt_ctl_model: memory controller side, drives commands just after each edge.
   Assumes callers keep all spacing that binds the controller. */
`timescale 1ns/1ps
module sdt_ctl_model (
  input  wire logic                  i_clk,
  output sdt_pkg::sdt_cmd_s          o_cmd,
  output logic [3:0]                 o_col,
  output logic [31:0]                o_dq,
  output logic [3:0]                 o_dqm,
  output logic                       o_cke,
  output logic [1:0]                 o_rl
);
  initial begin
    o_cmd = {sdt_pkg::SDT_NOP, 6'h01};
    o_col = 4'h0;
    o_dq = 32'h0;
    o_dqm = 4'h0;
    o_cke = 1'b1;
    o_rl = sdt_pkg::RL_TWO;
  end
  // no refresh or init: core keeps no such counters
  // spacing kept by callers
  task automatic op(input logic [3:0] c, input logic [3:0] col, input logic [31:0] d, input logic [3:0] m,
                    input logic drv);
    @(posedge i_clk);
    #1;
    o_cmd = {c, 6'h01};
    o_col = col;
    o_dq = drv ? d : ~o_dq; // released bus toggles so no stale value reads back
    o_dqm = m;
  endtask
  task automatic set_rl(input logic [1:0] v);
    o_rl = v;
  endtask
  task automatic gate(input logic v);
    @(posedge i_clk);
    #1;
    o_cke = v;
  endtask
endmodule

/* File: tb/testbench.sv */
/* testbench: directed scenarios for sdt_core through the controller model.
   Assumes a 200 MHz clock and a 3-cycle reset. */
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] NOP = sdt_pkg::SDT_NOP, RD = sdt_pkg::SDT_READ, WR = sdt_pkg::SDT_WRITE;
  logic              i_clk = 1'b0;
  logic              i_nrst = 1'b0;
  sdt_pkg::sdt_cmd_s cmd;
  logic [3:0]        col, dqm, oe;
  logic [31:0]       dq, rdq;
  logic              cke, susp;
  logic [1:0]        rl;
  int                err_total = 0;
  int                comparisons = 0;
  always #2.5 i_clk = ~i_clk;
  sdt_ctl_model u_ctl (.i_clk(i_clk), .o_cmd(cmd), .o_col(col), .o_dq(dq), .o_dqm(dqm), .o_cke(cke), .o_rl(rl));
  sdt_core u_sdt_core (.i_clk(i_clk), .i_nrst(i_nrst), .i_cke(cke), .i_cmd(cmd), .i_col(col), .i_dq(dq),
    .i_dqm(dqm), .i_read_latency_setting(rl), .o_dq(rdq), .o_dq_oe(oe), .o_suspended(susp));
  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_write(input logic [31:0] base, input logic [3:0] m1);
    for (int k = 0; k < 4; k++) u_ctl.op(k == 0 ? WR : NOP, 4'h0, base + k, k == 1 ? m1 : 4'h0, 1'b1);
  endtask
  task automatic t_back_to_back();
    logic [31:0] exp [4];
    exp = '{32'hb0b0_b0b2, 32'hb0b0_b0b0, 32'hb0b0_b0a1, 32'hb0b0_b0b2};
    u_ctl.op(sdt_pkg::SDT_ACTIVE, 4'h0, 32'h0, 4'h0, 1'b0);
    repeat (2) u_ctl.op(NOP, 4'h0, 32'h0, 4'h0, 1'b0);
    t_write(32'ha0a0_a0a0, 4'h0);
    t_write(32'hb0b0_b0b0, 4'h1); // lane 0 of beat 1 keeps old byte
    u_ctl.op(RD, 4'h2, 32'h0, 4'h0, 1'b0);
    u_ctl.op(RD, 4'h0, 32'h0, 4'h0, 1'b0);
    u_ctl.op(NOP, 4'h0, 32'h0, 4'h0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      chk(rdq, exp[k]);
      chk({28'h0, oe}, 32'hf);
      u_ctl.op(NOP, 4'h0, 32'h0, 4'h0, 1'b0);
    end
    $display("back_to_back finished");
  endtask
  task automatic t_cut();
    logic [3:0] exp [4];
    exp = '{4'hd, 4'hf, 4'h0, 4'h0};
    u_ctl.set_rl(sdt_pkg::RL_THREE);
    u_ctl.op(RD, 4'h0, 32'h0, 4'h0, 1'b0);
    u_ctl.op(NOP, 4'h0, 32'h0, 4'h2, 1'b0);
    u_ctl.op(sdt_pkg::SDT_PRECHG, 4'h0, 32'h0, 4'h0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      u_ctl.op(NOP, 4'h0, 32'h0, 4'h0, 1'b0);
      chk({28'h0, oe}, {28'h0, exp[k]});
      if (k < 2) chk(rdq, k == 0 ? 32'hb0b0_b0b0 : 32'hb0b0_b0a1);
    end
    $display("cut finished");
  endtask
  task automatic t_suspend();
    u_ctl.set_rl(sdt_pkg::RL_TWO);
    u_ctl.gate(1'b0);
    u_ctl.op(NOP, 4'h0, 32'h0, 4'h0, 1'b0);
    chk({31'h0, susp}, 32'h1);
    u_ctl.op(RD, 4'h0, 32'h0, 4'h0, 1'b0);
    u_ctl.gate(1'b1);
    u_ctl.op(NOP, 4'h0, 32'h0, 4'h0, 1'b0);
    chk({31'h0, susp}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      u_ctl.op(NOP, 4'h0, 32'h0, 4'h0, 1'b0);
      chk({28'h0, oe}, 32'h0);
    end
    $display("suspend finished");
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    chk({27'h0, oe, susp}, 32'h0);
    t_back_to_back();
    t_cut();
    t_suspend();
    stop_test();
  end
  initial begin
    #2000;
    err_total++;
    stop_test();
  end
endmodule
